// ==== rtl/ipd_pkg.sv ====
// constants and types of the interprocessor doorbell block
package ipd_pkg;
  localparam logic [31:0] ICR_ARB_ADDR = 32'h2000_1F40;
  localparam logic [31:0] SCR_ADDR = 32'h2008_0000;
  localparam logic [31:0] MBR_ADDR = 32'h2008_0010;
  localparam int ICR_DMA_ERR = 15;
  localparam int ICR_FLUSH = 14;
  localparam int ICR_HALT = 8;
  localparam int ICR_IE = 6;
  localparam int ICR_EAE = 5;
  localparam int ICR_RQ = 0;
  localparam int SCR_SEL_LO = 1;
  localparam int SCR_SEL_HI = 3;
  localparam int SCR_AUX = 10;
  localparam int SCR_HALT_EN = 14;
  localparam int SCR_POK = 15;
  localparam int MBR_LO = 15;
  localparam int MBR_HI = 28;
  localparam logic [3:0] BE_LONG = 4'hF;
  localparam logic [9:0] DOORBELL_VEC = 10'h204;
  localparam logic [4:0] IPL_BR4 = 5'h14;
  localparam logic [4:0] IPL_BR5 = 5'h15;
  localparam logic [4:0] IPL_BR6 = 5'h16;
  localparam logic [4:0] IPL_BR7 = 5'h17;
  localparam logic [4:0] IPL_IVT = 5'h16;
  localparam logic [4:0] IPL_AFTER_BR = 5'h17;
  localparam logic [4:0] IPL_AFTER_IVT = 5'h16;
  localparam logic [4:0] IPL_AFTER_LOCAL = 5'h14;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_BR7, SRC_IVT, SRC_BR6, SRC_BR5,
    SRC_CONSOLE, SRC_TIMER, SRC_DOORBELL, SRC_BR4
  } ipd_src_t;
  typedef enum logic {CFG_IDLE, CFG_WAIT} ipd_cfg_t;
endpackage : ipd_pkg

// ==== rtl/ipd_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ipd_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ipd_sync_st_t;
  ipd_sync_st_t q, d;
  always_comb begin
    d.s1 = i_d;
    d.s2 = q.s1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign o_q = q.s2;
endmodule : ipd_sync
`default_nettype wire

// ==== rtl/ipd_doorbell.sv ====
// communication, configuration and interrupt ranking logic
`timescale 1ns/10ps
`default_nettype none
module ipd_doorbell (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_bus_rd,
  input wire logic i_bus_wr,
  input wire logic [1:0] i_bus_be,
  input wire logic [15:0] i_bus_wdata,
  input wire logic i_self_master,
  output logic o_bus_ack,
  output logic [15:0] o_bus_rdata,
  input wire logic [31:0] i_cpu_addr,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_wr,
  input wire logic [3:0] i_cpu_be,
  input wire logic [31:0] i_cpu_wdata,
  output logic o_cpu_ack,
  output logic o_cpu_err,
  output logic [31:0] o_cpu_rdata,
  output logic o_bus_request,
  input wire logic i_bus_grant,
  input wire logic i_dc_power_good,
  input wire logic i_io_reset_write,
  input wire logic i_dma_memory_error_flag,
  input wire logic i_slave_nonexistent_flag,
  input wire logic i_aux_strap,
  input wire logic i_bus_pok,
  input wire logic i_bus_halt,
  input wire logic [3:0] i_bus_br,
  input wire logic i_console_irq,
  input wire logic i_timer_irq,
  input wire logic i_interval_timer_irq,
  input wire logic [4:0] i_cpu_ipl,
  input wire logic i_int_ack,
  output logic o_int_req,
  output logic [4:0] o_int_level,
  output logic [9:0] o_int_vector,
  output logic o_iack_cycle,
  output logic o_set_ipl_valid,
  output logic [4:0] o_set_ipl,
  output logic o_map_cache_flush_all,
  output logic o_remote_halt_request,
  output logic o_local_mem_external_enable,
  output logic o_doorbell_int_request,
  output logic o_cpu_halt
);
  localparam int MBR_W = ipd_pkg::MBR_HI - ipd_pkg::MBR_LO + 1;
  typedef struct packed {
    logic aux;
    logic aux_done;
    logic qme;
    logic dma_prev;
    logic halt_req;
    logic dbie;
    logic eae;
    logic dbrq;
    logic flush;
    logic [MBR_W-1:0] map_base;
    logic [2:0] sel;
    logic halt_en;
    logic cpu_halt;
    ipd_pkg::ipd_cfg_t cfg;
    logic bus_req;
    logic bus_ack;
    logic [15:0] bus_rdata;
    logic cpu_ack;
    logic cpu_err;
    logic [31:0] cpu_rdata;
    ipd_pkg::ipd_src_t src;
    logic [4:0] level;
    logic [9:0] vec;
    logic iack;
    logic set_ipl_v;
    logic [4:0] set_ipl;
  } ipd_state_t;

  ipd_state_t q, d;
  logic [7:0] pins_s;
  logic dc_power_good_s, pok_s, bhalt_s, aux_s;
  logic [3:0] br_s, br_eff;
  logic [31:0] icr_addr;
  logic icr_on, icr_hit, icr_wr, icr_rd, db_grant;
  logic cpu_req, mbr_sel, scr_sel;
  logic [15:0] icr_val;
  logic [31:0] scr_val, cpu_val;
  ipd_pkg::ipd_src_t src_n;

  ipd_sync #(.W(8)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d({i_bus_br, i_aux_strap, i_bus_halt, i_bus_pok, i_dc_power_good}),
    .o_q(pins_s)
  );
  assign dc_power_good_s = pins_s[0];
  assign pok_s = pins_s[1];
  assign bhalt_s = pins_s[2];
  assign aux_s = pins_s[3];
  assign br_s = pins_s[7:4];

  // register address from role and select
  assign icr_addr = q.aux ? ipd_pkg::ICR_ARB_ADDR + {28'h0, q.sel, 1'b0}
                          : ipd_pkg::ICR_ARB_ADDR;
  assign icr_on = !q.aux || (q.sel != 3'h0);
  assign icr_hit = icr_on && (i_bus_addr == icr_addr);
  assign icr_wr = i_bus_wr && icr_hit;
  assign icr_rd = i_bus_rd && icr_hit;
  assign db_grant = i_int_ack && (q.src == ipd_pkg::SRC_DOORBELL);
  assign cpu_req = (i_cpu_rd || i_cpu_wr) && !q.cpu_ack;
  assign mbr_sel = i_cpu_addr == ipd_pkg::MBR_ADDR;
  assign scr_sel = i_cpu_addr == ipd_pkg::SCR_ADDR;
  assign br_eff = q.aux ? 4'h0 : br_s;

  // read images
  always_comb begin
    icr_val = '0;
    icr_val[ipd_pkg::ICR_DMA_ERR] = q.qme;
    icr_val[ipd_pkg::ICR_HALT] = q.halt_req;
    icr_val[ipd_pkg::ICR_IE] = q.dbie;
    icr_val[ipd_pkg::ICR_EAE] = q.eae;
    icr_val[ipd_pkg::ICR_RQ] = q.dbrq;
    scr_val = '0;
    scr_val[ipd_pkg::SCR_SEL_HI:ipd_pkg::SCR_SEL_LO] = q.sel;
    scr_val[ipd_pkg::SCR_AUX] = q.aux;
    scr_val[ipd_pkg::SCR_HALT_EN] = q.halt_en;
    scr_val[ipd_pkg::SCR_POK] = pok_s;
    cpu_val = '0;
    if (scr_sel) begin
      cpu_val = scr_val;
    end else if (mbr_sel) begin
      cpu_val[ipd_pkg::MBR_HI:ipd_pkg::MBR_LO] = q.map_base;
    end
  end

  // interrupt ranking
  always_comb begin
    src_n = ipd_pkg::SRC_NONE;
    if (br_eff[3] && i_cpu_ipl < ipd_pkg::IPL_BR7) begin
      src_n = ipd_pkg::SRC_BR7;
    end else if (i_interval_timer_irq && i_cpu_ipl < ipd_pkg::IPL_IVT) begin
      src_n = ipd_pkg::SRC_IVT;
    end else if (br_eff[2] && i_cpu_ipl < ipd_pkg::IPL_BR6) begin
      src_n = ipd_pkg::SRC_BR6;
    end else if (br_eff[1] && i_cpu_ipl < ipd_pkg::IPL_BR5) begin
      src_n = ipd_pkg::SRC_BR5;
    end else if (i_cpu_ipl < ipd_pkg::IPL_BR4) begin
      if (i_console_irq) begin
        src_n = ipd_pkg::SRC_CONSOLE;
      end else if (i_timer_irq) begin
        src_n = ipd_pkg::SRC_TIMER;
      end else if (q.dbrq) begin
        src_n = ipd_pkg::SRC_DOORBELL;
      end else if (br_eff[0]) begin
        src_n = ipd_pkg::SRC_BR4;
      end
    end
  end

  always_comb begin
    d = q;
    d.flush = 1'b0;
    d.bus_ack = 1'b0;
    d.cpu_ack = 1'b0;
    d.cpu_err = 1'b0;
    d.iack = 1'b0;
    d.set_ipl_v = 1'b0;
    d.dma_prev = i_dma_memory_error_flag;
    if (!q.aux_done) begin
      d.aux = aux_s;
      d.aux_done = dc_power_good_s; // strap valid once chain carries power good
    end
    // acknowledge of the presented source
    if (i_int_ack && q.src != ipd_pkg::SRC_NONE) begin
      d.set_ipl_v = 1'b1;
      unique case (q.src)
        ipd_pkg::SRC_IVT: d.set_ipl = ipd_pkg::IPL_AFTER_IVT;
        ipd_pkg::SRC_CONSOLE, ipd_pkg::SRC_TIMER,
        ipd_pkg::SRC_DOORBELL: d.set_ipl = ipd_pkg::IPL_AFTER_LOCAL;
        default: begin
          d.set_ipl = ipd_pkg::IPL_AFTER_BR;
          d.iack = 1'b1;
        end
      endcase
    end
    if (db_grant) begin
      d.dbrq = 1'b0;
    end
    // I/O reset write
    if (i_io_reset_write) begin
      d.qme = 1'b0;
      d.halt_req = 1'b0;
      d.dbie = 1'b0;
      if (q.aux) begin
        d.eae = 1'b0;
      end
    end
    if (q.dma_prev && !i_dma_memory_error_flag) begin
      d.qme = 1'b0;
    end
    if (i_dma_memory_error_flag || i_slave_nonexistent_flag) begin
      d.qme = 1'b1;
    end
    // backplane access to the communication register
    d.bus_ack = icr_wr || icr_rd;
    if (icr_rd) begin
      d.bus_rdata = icr_val;
    end
    if (icr_wr) begin
      if (i_bus_be[1]) begin
        d.flush = i_bus_wdata[ipd_pkg::ICR_FLUSH];
        if (q.aux) begin
          d.halt_req = i_bus_wdata[ipd_pkg::ICR_HALT];
        end
      end
      if (i_bus_be[0]) begin
        if (i_self_master) begin
          d.dbie = i_bus_wdata[ipd_pkg::ICR_IE];
          d.eae = i_bus_wdata[ipd_pkg::ICR_EAE];
        end
        if (i_bus_wdata[ipd_pkg::ICR_RQ]) begin
          d.dbrq = 1'b1;
        end
      end
    end
    // local CPU access
    unique case (q.cfg)
      ipd_pkg::CFG_IDLE: begin
        if (cpu_req) begin
          if (mbr_sel && i_cpu_be != ipd_pkg::BE_LONG) begin
            d.cpu_ack = 1'b1;
            d.cpu_err = 1'b1;
            d.cpu_rdata = '0;
          end else if (scr_sel && i_cpu_wr) begin
            d.cfg = ipd_pkg::CFG_WAIT;
            d.bus_req = 1'b1;
          end else begin
            d.cpu_ack = 1'b1;
            d.cpu_rdata = i_cpu_rd ? cpu_val : '0;
            if (i_cpu_wr && mbr_sel) begin
              d.map_base = i_cpu_wdata[ipd_pkg::MBR_HI:ipd_pkg::MBR_LO];
              d.flush = 1'b1;
            end
          end
        end
      end
      ipd_pkg::CFG_WAIT: begin
        if (i_bus_grant) begin
          if (i_cpu_be[0]) begin
            d.sel = i_cpu_wdata[ipd_pkg::SCR_SEL_HI:ipd_pkg::SCR_SEL_LO];
          end
          if (i_cpu_be[1]) begin
            d.halt_en = i_cpu_wdata[ipd_pkg::SCR_HALT_EN];
          end
          d.cpu_ack = 1'b1;
          d.cpu_rdata = '0;
          d.bus_req = 1'b0;
          d.cfg = ipd_pkg::CFG_IDLE;
        end
      end
    endcase
    // power fault clears win over everything
    if (!dc_power_good_s) begin
      d.qme = 1'b0;
      d.halt_req = 1'b0;
      d.dbie = 1'b0;
      d.eae = 1'b0;
      d.dbrq = 1'b0;
      d.sel = 3'h0;
      d.halt_en = 1'b0;
    end
    if (!d.dbie) begin
      d.dbrq = 1'b0;
    end
    d.cpu_halt = (q.aux && q.halt_req)
               || (q.halt_en && bhalt_s);
    d.src = src_n;
    d.vec = '0;
    unique case (src_n)
      ipd_pkg::SRC_BR7: d.level = ipd_pkg::IPL_BR7;
      ipd_pkg::SRC_IVT: d.level = ipd_pkg::IPL_IVT;
      ipd_pkg::SRC_BR6: d.level = ipd_pkg::IPL_BR6;
      ipd_pkg::SRC_BR5: d.level = ipd_pkg::IPL_BR5;
      ipd_pkg::SRC_NONE: d.level = '0;
      default: d.level = ipd_pkg::IPL_BR4;
    endcase
    if (src_n == ipd_pkg::SRC_DOORBELL) begin
      d.vec = ipd_pkg::DOORBELL_VEC;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_bus_ack = q.bus_ack;
  assign o_bus_rdata = q.bus_rdata;
  assign o_cpu_ack = q.cpu_ack;
  assign o_cpu_err = q.cpu_err;
  assign o_cpu_rdata = q.cpu_rdata;
  assign o_bus_request = q.bus_req;
  assign o_int_req = q.src != ipd_pkg::SRC_NONE;
  assign o_int_level = q.level;
  assign o_int_vector = q.vec;
  assign o_iack_cycle = q.iack;
  assign o_set_ipl_valid = q.set_ipl_v;
  assign o_set_ipl = q.set_ipl;
  assign o_map_cache_flush_all = q.flush;
  assign o_remote_halt_request = q.halt_req;
  assign o_local_mem_external_enable = q.eae;
  assign o_doorbell_int_request = q.dbrq;
  assign o_cpu_halt = q.cpu_halt;

  // checks
  property p_byte_lane;
    @(posedge i_mclk) disable iff (i_rst)
      (icr_wr && i_bus_be == 2'b01 && dc_power_good_s && !i_io_reset_write)
      |=> $stable(q.halt_req);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("low byte write changed high byte");

  property p_arb_decode;
    @(posedge i_mclk) disable iff (i_rst)
      (!q.aux && i_bus_rd && i_bus_addr == ipd_pkg::ICR_ARB_ADDR)
      |=> o_bus_ack;
  endproperty
  a_arb_decode: assert property (p_arb_decode)
    else $error("arbiter register address not answered");

  property p_err_bit;
    @(posedge i_mclk) disable iff (i_rst)
      (i_slave_nonexistent_flag && dc_power_good_s) |=> q.qme;
  endproperty
  a_err_bit: assert property (p_err_bit)
    else $error("error bit not set by error flag");

  property p_icr_flush;
    @(posedge i_mclk) disable iff (i_rst)
      (icr_wr && i_bus_be[1] && i_bus_wdata[ipd_pkg::ICR_FLUSH])
      |=> o_map_cache_flush_all ##1 !o_bus_rdata[ipd_pkg::ICR_FLUSH];
  endproperty
  a_icr_flush: assert property (p_icr_flush)
    else $error("flush bit write did not flush");

  property p_arb_no_halt;
    @(posedge i_mclk) disable iff (i_rst)
      (q.aux_done && !q.aux) |-> !o_cpu_halt || (q.halt_en || $past(q.halt_en));
  endproperty
  a_arb_no_halt: assert property (p_arb_no_halt)
    else $error("remote halt acted on arbiter");

  property p_req_needs_en;
    @(posedge i_mclk) disable iff (i_rst)
      !q.dbie |-> !o_doorbell_int_request;
  endproperty
  a_req_needs_en: assert property (p_req_needs_en)
    else $error("doorbell request without enable");

  property p_grant_clears;
    @(posedge i_mclk) disable iff (i_rst)
      (db_grant && !icr_wr) |=> !q.dbrq ##1 o_set_ipl == ipd_pkg::IPL_AFTER_LOCAL;
  endproperty
  a_grant_clears: assert property (p_grant_clears)
    else $error("grant did not clear doorbell");

  property p_ipl_doorbell;
    @(posedge i_mclk) disable iff (i_rst)
      db_grant |=> o_set_ipl_valid && o_set_ipl == ipd_pkg::IPL_AFTER_LOCAL;
  endproperty
  a_ipl_doorbell: assert property (p_ipl_doorbell)
    else $error("wrong priority after doorbell");

  property p_mbr_flush;
    @(posedge i_mclk) disable iff (i_rst)
      (q.cfg == ipd_pkg::CFG_IDLE && cpu_req && i_cpu_wr && mbr_sel
       && i_cpu_be == ipd_pkg::BE_LONG) |=> o_map_cache_flush_all && o_cpu_ack;
  endproperty
  a_mbr_flush: assert property (p_mbr_flush)
    else $error("map base write did not flush");

  property p_scr_wait;
    @(posedge i_mclk) disable iff (i_rst)
      (q.cfg == ipd_pkg::CFG_WAIT && !i_bus_grant && dc_power_good_s)
      |=> $stable(q.sel) && !o_cpu_ack && o_bus_request;
  endproperty
  a_scr_wait: assert property (p_scr_wait)
    else $error("configuration updated before mastership");
endmodule : ipd_doorbell
`default_nettype wire

// ==== tb/ipd_bus_master.sv ====
// backplane master model issuing single-cycle register accesses
`timescale 1ns/10ps
`default_nettype none
module ipd_bus_master (
  input wire logic i_mclk,
  input wire logic i_ack,
  input wire logic [15:0] i_rdata,
  output logic [31:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [1:0] o_be,
  output logic [15:0] o_wdata
);
  initial begin
    o_addr = 32'h0000_0000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_be = 2'h0;
    o_wdata = 16'h0000;
  end
  // one strobe cycle, answer sampled 1 ns after the taking edge
  task automatic access(input logic wr, input logic [31:0] addr,
      input logic [1:0] be, input logic [15:0] wdata,
      output logic acked, output logic [15:0] rdata);
    @(posedge i_mclk);
    o_addr <= addr;
    o_be <= be;
    o_wdata <= wdata;
    o_wr <= wr;
    o_rd <= ~wr;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // released address and data lines carry no stale value
    o_addr <= ~addr;
    o_wdata <= ~wdata;
    #1;
    acked = i_ack;
    rdata = i_rdata;
  endtask : access
endmodule : ipd_bus_master
`default_nettype wire

// ==== tb/interprocessor_doorbell_config_tb.sv ====
// self-checking bench for the interprocessor doorbell block
`timescale 1ns/10ps
`default_nettype none
module interprocessor_doorbell_config_tb;
  localparam logic [31:0] ARB = ipd_pkg::ICR_ARB_ADDR;
  localparam logic [31:0] AUX1 = ipd_pkg::ICR_ARB_ADDR + 32'h2;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_self_master = 1'b0;
  logic [31:0] i_cpu_addr = 32'h0, i_cpu_wdata = 32'h0;
  logic i_cpu_rd = 1'b0, i_cpu_wr = 1'b0, i_bus_grant = 1'b0;
  logic [3:0] i_cpu_be = 4'h0, i_bus_br = 4'h0;
  logic i_dc_power_good = 1'b1, i_io_reset_write = 1'b0;
  logic i_dma_memory_error_flag = 1'b0, i_slave_nonexistent_flag = 1'b0;
  logic i_aux_strap = 1'b0, i_bus_pok = 1'b1, i_bus_halt = 1'b0;
  logic i_console_irq = 1'b0, i_timer_irq = 1'b0;
  logic i_interval_timer_irq = 1'b0, i_int_ack = 1'b0;
  logic [4:0] i_cpu_ipl = 5'h00;
  wire [31:0] bm_addr, o_cpu_rdata;
  wire [15:0] bm_wdata, o_bus_rdata;
  wire [1:0] bm_be;
  wire [4:0] o_int_level, o_set_ipl;
  wire [9:0] o_int_vector;
  wire bm_rd, bm_wr, o_bus_ack, o_cpu_ack, o_cpu_err, o_bus_request;
  wire o_int_req, o_iack_cycle, o_set_ipl_valid, o_map_cache_flush_all;
  wire o_remote_halt_request, o_local_mem_external_enable;
  wire o_doorbell_int_request, o_cpu_halt;
  int n_errors = 0, comparisons = 0, n_flush = 0, n_req = 0;
  logic [31:0] rd;
  logic err;

  ipd_doorbell dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus_addr(bm_addr),
    .i_bus_rd(bm_rd), .i_bus_wr(bm_wr), .i_bus_be(bm_be),
    .i_bus_wdata(bm_wdata), .i_self_master(i_self_master),
    .o_bus_ack(o_bus_ack), .o_bus_rdata(o_bus_rdata),
    .i_cpu_addr(i_cpu_addr), .i_cpu_rd(i_cpu_rd), .i_cpu_wr(i_cpu_wr),
    .i_cpu_be(i_cpu_be), .i_cpu_wdata(i_cpu_wdata), .o_cpu_ack(o_cpu_ack),
    .o_cpu_err(o_cpu_err), .o_cpu_rdata(o_cpu_rdata),
    .o_bus_request(o_bus_request), .i_bus_grant(i_bus_grant),
    .i_dc_power_good(i_dc_power_good), .i_io_reset_write(i_io_reset_write),
    .i_dma_memory_error_flag(i_dma_memory_error_flag),
    .i_slave_nonexistent_flag(i_slave_nonexistent_flag),
    .i_aux_strap(i_aux_strap), .i_bus_pok(i_bus_pok),
    .i_bus_halt(i_bus_halt), .i_bus_br(i_bus_br),
    .i_console_irq(i_console_irq), .i_timer_irq(i_timer_irq),
    .i_interval_timer_irq(i_interval_timer_irq), .i_cpu_ipl(i_cpu_ipl),
    .i_int_ack(i_int_ack), .o_int_req(o_int_req),
    .o_int_level(o_int_level), .o_int_vector(o_int_vector),
    .o_iack_cycle(o_iack_cycle), .o_set_ipl_valid(o_set_ipl_valid),
    .o_set_ipl(o_set_ipl), .o_map_cache_flush_all(o_map_cache_flush_all),
    .o_remote_halt_request(o_remote_halt_request),
    .o_local_mem_external_enable(o_local_mem_external_enable),
    .o_doorbell_int_request(o_doorbell_int_request),
    .o_cpu_halt(o_cpu_halt));

  ipd_bus_master bm (.i_mclk(i_mclk), .i_ack(o_bus_ack),
    .i_rdata(o_bus_rdata), .o_addr(bm_addr), .o_rd(bm_rd), .o_wr(bm_wr),
    .o_be(bm_be), .o_wdata(bm_wdata));

  always #20 i_mclk = ~i_mclk;
  // arbiter grants whatever is asked, one cycle later
  always @(posedge i_mclk) begin
    i_bus_grant <= o_bus_request;
    if (o_map_cache_flush_all === 1'b1) n_flush <= n_flush + 1;
    if (o_bus_request === 1'b1) n_req <= n_req + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc

  task automatic do_reset(input logic aux);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    i_aux_strap <= aux;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    cyc(6);
  endtask : do_reset

  // backplane access judged on ack and, for reads expected to be acked, data
  task automatic bus(input logic wr, input logic [31:0] addr,
      input logic [1:0] be, input logic [15:0] wd, input logic ack_exp,
      input logic [15:0] rd_exp);
    logic a;
    logic [15:0] r;
    bm.access(wr, addr, be, wd, a, r);
    chk(a, ack_exp);
    if (!wr && ack_exp) chk(r, rd_exp);
  endtask : bus

  task automatic cpu(input logic wr, input logic [31:0] addr,
      input logic [3:0] be, input logic [31:0] wd);
    int k;
    @(posedge i_mclk);
    i_cpu_addr <= addr;
    i_cpu_be <= be;
    i_cpu_wdata <= wd;
    i_cpu_wr <= wr;
    i_cpu_rd <= ~wr;
    for (k = 0; k < 20 && o_cpu_ack !== 1'b1; k++) begin
      @(posedge i_mclk);
      #1;
    end
    if (k == 20) begin
      n_errors++;
      $display("MISMATCH at %0t: cpu access never answered", $time);
      final_report();
    end
    rd = o_cpu_rdata;
    err = o_cpu_err;
    @(posedge i_mclk);
    i_cpu_rd <= 1'b0;
    i_cpu_wr <= 1'b0;
  endtask : cpu

  task automatic irq_ack(input logic [4:0] ipl, input logic iack);
    @(posedge i_mclk);
    i_int_ack <= 1'b1;
    i_bus_br <= 4'h0;
    i_interval_timer_irq <= 1'b0;
    @(posedge i_mclk);
    i_int_ack <= 1'b0;
    #1;
    chk(o_set_ipl_valid, 1'b1);
    chk(o_set_ipl, ipl);
    chk(o_iack_cycle, iack);
  endtask : irq_ack

  task automatic io_rst();
    @(posedge i_mclk);
    i_io_reset_write <= 1'b1;
    @(posedge i_mclk);
    i_io_reset_write <= 1'b0;
    cyc(2);
  endtask : io_rst

  task automatic t_reset_values();
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h0000);
    bus(1'b0, AUX1, 2'h3, 16'h0, 1'b0, 16'h0000);
    cpu(1'b0, ipd_pkg::SCR_ADDR, 4'hF, 32'h0);
    chk(rd, 32'h0000_8000);
  endtask : t_reset_values

  task automatic t_doorbell();
    int f0;
    i_self_master <= 1'b1;
    f0 = n_flush;
    bus(1'b1, ARB, 2'h3, 16'h0060, 1'b1, 16'h0);
    bus(1'b1, ARB, 2'h3, 16'h4161, 1'b1, 16'h0);
    cyc(2);
    chk(n_flush, f0 + 1);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h0061);
    chk(o_doorbell_int_request, 1'b1);
    chk(o_local_mem_external_enable, 1'b1);
    chk(o_int_req, 1'b1);
    chk(o_int_vector, ipd_pkg::DOORBELL_VEC);
    chk(o_int_level, 5'h14);
    irq_ack(5'h14, 1'b0);
    chk(o_doorbell_int_request, 1'b0);
    cyc(2);
    chk(o_int_req, 1'b0);
  endtask : t_doorbell

  task automatic t_master_gate();
    i_self_master <= 1'b0;
    bus(1'b1, ARB, 2'h1, 16'h0000, 1'b1, 16'h0);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h0060);
    i_self_master <= 1'b1;
    bus(1'b1, ARB, 2'h2, 16'h0000, 1'b1, 16'h0);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h0060);
    i_dma_memory_error_flag <= 1'b1;
    cyc(3);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h8060);
    i_dma_memory_error_flag <= 1'b0;
    cyc(3);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h0060);
    i_slave_nonexistent_flag <= 1'b1;
    cyc(3);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h8060);
    i_slave_nonexistent_flag <= 1'b0;
    io_rst();
    i_self_master <= 1'b0;
    bus(1'b1, ARB, 2'h3, 16'h0001, 1'b1, 16'h0);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b1, 16'h0020);
    chk(o_int_req, 1'b0);
  endtask : t_master_gate

  task automatic t_map_base();
    int f0;
    f0 = n_flush;
    cpu(1'b1, ipd_pkg::MBR_ADDR, 4'hF, 32'hFFFF_FFFF);
    chk(err, 1'b0);
    cyc(2);
    chk(n_flush, f0 + 1);
    cpu(1'b1, ipd_pkg::MBR_ADDR, 4'h3, 32'h0000_0000);
    chk(err, 1'b1);
    cpu(1'b0, ipd_pkg::MBR_ADDR, 4'hF, 32'h0);
    chk(rd, 32'h1FFF_8000);
  endtask : t_map_base

  task automatic t_config();
    int r0;
    r0 = n_req;
    cpu(1'b1, ipd_pkg::SCR_ADDR, 4'hF, 32'h0000_4000);
    chk(n_req - r0, 2);
    i_bus_halt <= 1'b1;
    cyc(4);
    chk(o_cpu_halt, 1'b1);
    i_bus_pok <= 1'b0;
    cyc(4);
    cpu(1'b0, ipd_pkg::SCR_ADDR, 4'hF, 32'h0);
    chk(rd, 32'h0000_4000);
    i_bus_pok <= 1'b1;
    cpu(1'b1, ipd_pkg::SCR_ADDR, 4'hF, 32'h0000_0000);
    cyc(4);
    chk(o_cpu_halt, 1'b0);
    i_bus_halt <= 1'b0;
  endtask : t_config

  task automatic t_priority();
    i_bus_br <= 4'h1;
    cyc(5);
    chk(o_int_level, 5'h14);
    irq_ack(5'h17, 1'b1);
    i_cpu_ipl <= 5'h17;
    i_bus_br <= 4'h8;
    cyc(5);
    chk(o_int_req, 1'b0);
    i_cpu_ipl <= 5'h00;
    i_bus_br <= 4'h4;
    i_interval_timer_irq <= 1'b1;
    cyc(5);
    chk(o_int_level, 5'h16);
    irq_ack(5'h16, 1'b0);
  endtask : t_priority

  task automatic t_aux();
    do_reset(1'b1);
    i_self_master <= 1'b1;
    bus(1'b0, AUX1, 2'h3, 16'h0, 1'b0, 16'h0);
    bus(1'b0, ARB, 2'h3, 16'h0, 1'b0, 16'h0);
    cpu(1'b1, ipd_pkg::SCR_ADDR, 4'hF, 32'h0000_0002);
    cpu(1'b0, ipd_pkg::SCR_ADDR, 4'hF, 32'h0);
    chk(rd, 32'h0000_8402);
    bus(1'b1, AUX1, 2'h3, 16'h0120, 1'b1, 16'h0);
    cyc(2);
    chk(o_remote_halt_request, 1'b1);
    chk(o_cpu_halt, 1'b1);
    io_rst();
    bus(1'b0, AUX1, 2'h3, 16'h0, 1'b1, 16'h0000);
    chk(o_remote_halt_request, 1'b0);
    i_bus_br <= 4'hF;
    cyc(5);
    chk(o_int_req, 1'b0);
    i_bus_br <= 4'h0;
    bus(1'b1, AUX1, 2'h3, 16'h0040, 1'b1, 16'h0);
    bus(1'b1, AUX1, 2'h3, 16'h0041, 1'b1, 16'h0);
    cyc(2);
    chk(o_int_level, 5'h14);
    chk(o_int_vector, ipd_pkg::DOORBELL_VEC);
    i_timer_irq <= 1'b1;
    cyc(2);
    chk(o_int_vector, 10'h000);
    i_timer_irq <= 1'b0;
  endtask : t_aux

  initial begin
    do_reset(1'b0);
    t_reset_values();
    t_doorbell();
    t_master_gate();
    t_map_base();
    t_config();
    t_priority();
    t_aux();
    final_report();
  end
endmodule : interprocessor_doorbell_config_tb
`default_nettype wire
